// File: rtl/frs_pkg.sv
package frs_pkg;

   // System clock period
   localparam int CLK_NS          = 50;
   localparam int CNT_W           = 20;
   localparam int BIT_W           = 4;

   // Least time to whole cycles, never below one
   function automatic int ns2cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // Reset timing
   localparam int POWERUP_NS      = 300000;
   localparam int SETUP_NS        = 50;
   localparam int PULSE_NS        = 200;
   localparam int HOLD_NS         = 50;
   localparam int RECOVERY_NS     = 35000;
   localparam int POWERUP_CYC     = ns2cyc(POWERUP_NS);
   localparam int SETUP_CYC       = ns2cyc(SETUP_NS);
   localparam int PULSE_CYC       = ns2cyc(PULSE_NS);
   localparam int HOLD_CYC        = ns2cyc(HOLD_NS);
   localparam int RECOVERY_CYC    = ns2cyc(RECOVERY_NS);
   localparam int SYNC_LAT        = 4;

   // Deselect time between commands
   localparam int DESEL_READ_NS   = 10;
   localparam int DESEL_PROG_NS   = 50;
   localparam int DESEL_READ_CYC  = ns2cyc(DESEL_READ_NS);
   localparam int DESEL_PROG_CYC  = ns2cyc(DESEL_PROG_NS);

   // Link clock limits per command class
   localparam int LINK_HALF_NS    = 400;
   localparam int RATE_PLAIN_MHZ  = 50;
   localparam int RATE_SINGLE_MHZ = 133;
   localparam int RATE_MULTI_MHZ  = 104;
   localparam int RATE_QPP_MHZ    = 80;

   // Half period in cycles for a rate limit
   function automatic int half_cyc(input int mhz);
      int h;
      h = ns2cyc((1000 + 2 * mhz - 1) / (2 * mhz));
      return (h < ns2cyc(LINK_HALF_NS)) ? ns2cyc(LINK_HALF_NS) : h;
   endfunction

   localparam int BYTE_BITS       = 8;

   typedef logic [CNT_W-1:0] frs_cnt_t;

   typedef enum logic [1:0] {
      CLS_PLAIN_READ = 2'h0,
      CLS_SINGLE     = 2'h1,
      CLS_MULTI_READ = 2'h2,
      CLS_QPP        = 2'h3
   } frs_class_e;

   typedef enum logic [5:0] {
      D_POWERUP = 6'h01,
      D_RSTHOLD = 6'h02,
      D_PULSE   = 6'h04,
      D_RECOVER = 6'h08,
      D_STANDBY = 6'h10,
      D_ACTIVE  = 6'h20
   } frs_dstate_e;

   typedef enum logic [5:0] {
      H_POWERUP = 6'h01,
      H_IDLE    = 6'h02,
      H_SHIFT   = 6'h04,
      H_GAP     = 6'h08,
      H_RSTLOW  = 6'h10,
      H_RSTHOLD = 6'h20
   } frs_hstate_e;

endpackage

// File: rtl/frs_link_if.sv
`timescale 1ns/10ps
interface frs_link_if;
   logic sclk;
   logic cs_n;
   logic restart_n;
   logic si;
   logic so;
   logic so_oe_n;
   logic so_line;

   // Output line floats high while undriven
   assign so_line = so_oe_n ? 1'b1 : so;

   modport dev  (input sclk, cs_n, restart_n, si, output so, so_oe_n);
   modport host (output sclk, cs_n, restart_n, si, input so_line);
endinterface

// File: rtl/frs_sync.sv
`timescale 1ns/10ps
module frs_sync #(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] ff1;
   logic [W-1:0] ff2;
   logic [W-1:0] ff3;
   logic [W-1:0] next_q;

   // Take a bit only once stages two and three agree
   always_comb begin
      for (int i = 0; i < W; i++) begin
         next_q[i] = (ff2[i] == ff3[i]) ? ff3[i] : q[i];
      end
   end

   // Three stage chain
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ff1 <= INIT;
         ff2 <= INIT;
         ff3 <= INIT;
         q   <= INIT;
      end else if (clk_en) begin
         ff1 <= d;
         ff2 <= ff1;
         ff3 <= ff2;
         q   <= next_q;
      end
   end
endmodule

// File: rtl/frs_device.sv
`timescale 1ns/10ps
// Behaviour
// (RULE1) Cold start ends after full powerup interval
// (RULE2) Host keeps deselected during powerup interval
// (RULE3) Restart level ignored during cold start
// (RULE4) Restart low at powerup end delays select
// (RULE5) Restart low at powerup end holds reset
// (RULE6) Host keeps restart high before new restart
// (RULE7) Restart falling edge starts short recovery
// (RULE8) Failed cold start makes restart rerun powerup
// (RULE9) Long restart pulse aborts, floats, ignores commands
// (RULE10) Host deselects during recovery, then waits hold
// (RULE11) Pulse width plus hold covers recovery
// (RULE12) Plain reads at most 50 MHz
// (RULE13) Single line commands at most 133 MHz
// (RULE14) Dual and quad reads at most 104 MHz
// (RULE15) Quad page program at most 80 MHz
// (RULE16) Deselect 10 ns reads, 50 ns program
// (RULE17) Stay active until operation completes, then standby
// (RULE18) Powerup interval is a host parameter
module frs_device #(
   parameter int POWERUP_CYCLES = frs_pkg::POWERUP_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   frs_link_if.dev          link,
   input  wire logic        vcc_ok,
   input  wire logic        por_fail,
   input  wire logic        op_busy,
   input  wire logic [7:0]  tx_byte,
   output logic      [7:0]  rx_byte,
   output logic             rx_valid,
   output logic             op_abort,
   output logic             standby,
   output logic             in_reset
);
   import frs_pkg::*;

   localparam frs_cnt_t PU_END   = frs_cnt_t'(POWERUP_CYCLES);
   localparam frs_cnt_t PULS_END = frs_cnt_t'(PULSE_CYC);
   localparam frs_cnt_t RECV_END = frs_cnt_t'(RECOVERY_CYC);
   localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(BYTE_BITS - 1);

   // Synchronised link pins
   logic [3:0]       pins;
   logic             sclk_s;
   logic             cs_n_s;
   logic             rst_s;
   logic             si_s;

   frs_sync #(
      .W    (4),
      .INIT (4'h6)                                         // Idle: clock low, select high
   ) u_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .d       ({link.sclk, link.cs_n, link.restart_n, link.si}),
      .q       (pins)
   );

   assign {sclk_s, cs_n_s, rst_s, si_s} = pins;

   // Control state
   frs_dstate_e      state;
   frs_dstate_e      next_state;
   frs_cnt_t         cnt;
   frs_cnt_t         next_cnt;
   logic             por_bad;
   logic             next_por_bad;
   logic             sclk_d;
   logic             cs_n_d;
   logic             rst_d;
   logic             next_op_abort;
   logic             rst_fall;

   assign rst_fall = rst_d & ~rst_s;

   // Reset sequencing
   always_comb begin
      next_state    = state;
      next_cnt      = cnt;
      next_por_bad  = por_bad;
      next_op_abort = 1'b0;
      case (state)
         D_POWERUP: begin
            // Restart level looked at only when powerup ends
            next_cnt = cnt + frs_cnt_t'(1);                 // see (RULE3)
            if (cnt >= PU_END - frs_cnt_t'(1)) begin        // see (RULE1)
               next_cnt     = '0;
               next_por_bad = por_fail;
               if (!rst_s) begin
                  next_state = D_RSTHOLD;                   // see (RULE5)
               end else begin
                  next_state = D_STANDBY;
               end
            end
         end
         D_RSTHOLD: begin
            // Leave only when restart released
            if (rst_s) begin
               next_state = D_STANDBY;                      // see (RULE5)
            end
         end
         D_PULSE: begin
            next_cnt = cnt + frs_cnt_t'(1);
            if (rst_s) begin
               next_state = D_STANDBY;
            end else if (cnt >= PULS_END - frs_cnt_t'(1)) begin
               next_state    = D_RECOVER;                   // see (RULE9)
               next_op_abort = 1'b1;
            end
         end
         D_RECOVER: begin
            // Counted from the restart edge
            next_cnt = cnt + frs_cnt_t'(1);
            if (cnt >= RECV_END - frs_cnt_t'(1)) begin      // see (RULE7)
               next_cnt   = '0;
               next_state = rst_s ? D_STANDBY : D_RSTHOLD;
            end
         end
         D_STANDBY: begin
            if (!cs_n_s) begin
               next_state = D_ACTIVE;
            end
         end
         D_ACTIVE: begin
            // Deselected but busy stays active
            if (cs_n_s && !op_busy) begin
               next_state = D_STANDBY;                      // see (RULE17)
            end
         end
         default: begin
            next_state = D_POWERUP;
            next_cnt   = '0;
         end
      endcase
      // Restart edge in standby, active or restart hold
      if (rst_fall && (state == D_STANDBY || state == D_ACTIVE || state == D_RSTHOLD)) begin
         next_cnt = frs_cnt_t'(1);
         if (por_bad) begin
            next_state   = D_POWERUP;                       // see (RULE8)
            next_cnt     = '0;
            next_por_bad = 1'b0;
         end else begin
            next_state = D_PULSE;                           // see (RULE7)
         end
      end
      // Supply below threshold restarts cold start
      if (!vcc_ok) begin
         next_state = D_POWERUP;                            // see (RULE1)
         next_cnt   = '0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state    <= D_POWERUP;
         cnt      <= '0;
         por_bad  <= 1'b0;
         op_abort <= 1'b0;
         sclk_d   <= 1'b0;
         cs_n_d   <= 1'b1;
         rst_d    <= 1'b1;
      end else if (clk_en) begin
         state    <= next_state;
         cnt      <= next_cnt;
         por_bad  <= next_por_bad;
         op_abort <= next_op_abort;
         sclk_d   <= sclk_s;
         cs_n_d   <= cs_n_s;
         rst_d    <= rst_s;
      end
   end

   // Serial shift path
   logic [7:0]       rx_sh;
   logic [7:0]       next_rx_sh;
   logic [7:0]       tx_sh;
   logic [7:0]       next_tx_sh;
   logic [BIT_W-1:0] bits;
   logic [BIT_W-1:0] next_bits;
   logic [7:0]       next_rx_byte;
   logic             next_rx_valid;
   logic             next_so;
   logic             next_so_oe_n;
   logic             next_standby;
   logic             next_in_reset;
   logic             so_q;
   logic             so_oe_n_q;
   logic             live;

   assign live = (state == D_ACTIVE) && !cs_n_s;

   always_comb begin
      next_rx_sh    = rx_sh;
      next_tx_sh    = tx_sh;
      next_bits     = bits;
      next_rx_byte  = rx_byte;
      next_rx_valid = 1'b0;
      if (cs_n_d && !cs_n_s) begin
         next_tx_sh = tx_byte;
         next_bits  = '0;
      end else if (live && !sclk_d && sclk_s) begin
         // Commands only taken when active
         next_rx_sh = {rx_sh[6:0], si_s};                   // see (RULE9)
         next_bits  = bits + BIT_W'(1);
         if (bits == LAST_BIT) begin
            next_rx_byte  = {rx_sh[6:0], si_s};
            next_rx_valid = 1'b1;
            next_bits     = '0;
         end
      end else if (live && sclk_d && !sclk_s) begin
         next_tx_sh = {tx_sh[6:0], 1'b0};
      end
      // Registers cleared as on cold start
      if (state == D_POWERUP || rst_fall) begin
         next_rx_sh   = '0;                                 // see (RULE7)
         next_tx_sh   = '0;
         next_bits    = '0;
         next_rx_byte = '0;
      end
      next_so       = next_tx_sh[7];
      next_so_oe_n  = !(live && next_state == D_ACTIVE);    // see (RULE9)
      next_standby  = (next_state == D_STANDBY);
      next_in_reset = (next_state == D_POWERUP) || (next_state == D_RSTHOLD) ||
                      (next_state == D_PULSE) || (next_state == D_RECOVER);
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_sh     <= '0;
         tx_sh     <= '0;
         bits      <= '0;
         rx_byte   <= '0;
         rx_valid  <= 1'b0;
         so_q      <= 1'b0;
         so_oe_n_q <= 1'b1;
         standby   <= 1'b0;
         in_reset  <= 1'b1;
      end else if (clk_en) begin
         rx_sh     <= next_rx_sh;
         tx_sh     <= next_tx_sh;
         bits      <= next_bits;
         rx_byte   <= next_rx_byte;
         rx_valid  <= next_rx_valid;
         so_q      <= next_so;
         so_oe_n_q <= next_so_oe_n;
         standby   <= next_standby;
         in_reset  <= next_in_reset;
      end
   end

   // Link outputs straight from flops
   assign link.so      = so_q;
   assign link.so_oe_n = so_oe_n_q;
endmodule

// File: rtl/frs_host.sv
`timescale 1ns/10ps
module frs_host #(
   parameter int POWERUP_CYCLES = frs_pkg::POWERUP_CYC
) (
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic              clk_en,
   frs_link_if.host               link,
   input  wire logic              req,
   input  wire frs_pkg::frs_class_e req_class,
   input  wire logic [7:0]        req_byte,
   input  wire logic              warm_req,
   output logic                   ready,
   output logic                   power_good,
   output logic      [7:0]        rsp_byte,
   output logic                   rsp_valid
);
   import frs_pkg::*;

   localparam frs_cnt_t PU_END   = frs_cnt_t'(POWERUP_CYCLES);
   localparam frs_cnt_t LOW_END  = frs_cnt_t'(RECOVERY_CYC);
   localparam frs_cnt_t POST_END = frs_cnt_t'(HOLD_CYC + SETUP_CYC + SYNC_LAT);
   localparam frs_cnt_t DS_READ  = frs_cnt_t'(DESEL_READ_CYC);
   localparam frs_cnt_t DS_PROG  = frs_cnt_t'(DESEL_PROG_CYC);
   localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(BYTE_BITS - 1);

   // Half period allowed for a class
   function automatic frs_cnt_t class_half(input frs_class_e c);
      case (c)
         CLS_PLAIN_READ: return frs_cnt_t'(half_cyc(RATE_PLAIN_MHZ));
         CLS_MULTI_READ: return frs_cnt_t'(half_cyc(RATE_MULTI_MHZ));
         CLS_QPP:        return frs_cnt_t'(half_cyc(RATE_QPP_MHZ));
         default:        return frs_cnt_t'(half_cyc(RATE_SINGLE_MHZ));
      endcase
   endfunction

   logic        so_s;

   frs_sync #(
      .W    (1),
      .INIT (1'h1)
   ) u_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .d       (link.so_line),
      .q       (so_s)
   );

   frs_hstate_e      state;
   frs_hstate_e      next_state;
   frs_cnt_t         cnt;
   frs_cnt_t         next_cnt;
   frs_cnt_t         half;
   frs_cnt_t         next_half;
   frs_class_e       cls;
   frs_class_e       next_cls;
   logic [7:0]       sh;
   logic [7:0]       next_sh;
   logic [BIT_W-1:0] bits;
   logic [BIT_W-1:0] next_bits;
   logic             sclk;
   logic             next_sclk;
   logic             cs_n;
   logic             next_cs_n;
   logic             rst_o;
   logic             next_rst_o;
   logic             si;
   logic             next_si;
   logic [7:0]       next_rsp_byte;
   logic             next_rsp_valid;

   // Host sequencing and shifting
   always_comb begin
      next_state     = state;
      next_cnt       = cnt + frs_cnt_t'(1);
      next_half      = half;
      next_cls       = cls;
      next_sh        = sh;
      next_bits      = bits;
      next_sclk      = sclk;
      next_cs_n      = cs_n;
      next_rst_o     = rst_o;
      next_si        = si;
      next_rsp_byte  = rsp_byte;
      next_rsp_valid = 1'b0;
      case (state)
         H_POWERUP: begin
            // Deselected, no commands yet
            next_cs_n = 1'b1;                               // see (RULE2)
            if (cnt >= PU_END - frs_cnt_t'(1)) begin        // see (RULE18)
               next_state = H_RSTHOLD;                      // see (RULE4)
               next_cnt   = '0;
            end
         end
         H_IDLE: begin
            next_cnt = '0;
            if (warm_req) begin
               next_state = H_RSTLOW;
               next_rst_o = 1'b0;
               next_cs_n  = 1'b1;                           // see (RULE10)
            end else if (req) begin
               next_state = H_SHIFT;
               next_cls   = req_class;
               next_half  = class_half(req_class);          // see (RULE12) (RULE13)
               next_sh    = req_byte;                       // see (RULE14) (RULE15)
               next_si    = req_byte[7];
               next_bits  = '0;
               next_cs_n  = 1'b0;
            end
         end
         H_SHIFT: begin
            if (cnt >= half - frs_cnt_t'(1)) begin
               next_cnt  = '0;
               next_sclk = !sclk;
               if (sclk) begin
                  // End of high phase: sample, next bit
                  next_sh   = {sh[6:0], so_s};
                  next_si   = sh[6];
                  next_bits = bits + BIT_W'(1);
                  if (bits == LAST_BIT) begin
                     next_state     = H_GAP;
                     next_cs_n      = 1'b1;
                     next_rsp_byte  = {sh[6:0], so_s};
                     next_rsp_valid = 1'b1;
                  end
               end
            end
         end
         H_GAP: begin
            if (cnt >= ((cls == CLS_QPP || cls == CLS_SINGLE) ? DS_PROG : DS_READ)) begin
               next_state = H_IDLE;                         // see (RULE16)
               next_cnt   = '0;
            end
         end
         H_RSTLOW: begin
            // Low time alone covers recovery
            next_cs_n = 1'b1;                               // see (RULE10)
            if (cnt >= LOW_END - frs_cnt_t'(1)) begin       // see (RULE11)
               next_state = H_RSTHOLD;
               next_rst_o = 1'b1;
               next_cnt   = '0;
            end
         end
         H_RSTHOLD: begin
            // Hold before select, setup before restart
            next_rst_o = 1'b1;
            if (cnt >= POST_END - frs_cnt_t'(1)) begin      // see (RULE6)
               next_state = H_IDLE;
               next_cnt   = '0;
            end
         end
         default: begin
            next_state = H_POWERUP;
            next_cnt   = '0;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state      <= H_POWERUP;
         cnt        <= '0;
         half       <= '0;
         cls        <= CLS_PLAIN_READ;
         sh         <= '0;
         bits       <= '0;
         sclk       <= 1'b0;
         cs_n       <= 1'b1;
         rst_o      <= 1'b1;
         si         <= 1'b0;
         rsp_byte   <= '0;
         rsp_valid  <= 1'b0;
         ready      <= 1'b0;
         power_good <= 1'b0;
      end else if (clk_en) begin
         state      <= next_state;
         cnt        <= next_cnt;
         half       <= next_half;
         cls        <= next_cls;
         sh         <= next_sh;
         bits       <= next_bits;
         sclk       <= next_sclk;
         cs_n       <= next_cs_n;
         rst_o      <= next_rst_o;
         si         <= next_si;
         rsp_byte   <= next_rsp_byte;
         rsp_valid  <= next_rsp_valid;
         ready      <= (next_state == H_IDLE);
         power_good <= (next_state != H_POWERUP);
      end
   end

   assign link.sclk      = sclk;
   assign link.cs_n      = cs_n;
   assign link.restart_n = rst_o;
   assign link.si        = si;
endmodule

// File: sim/frs_assertions.sv
`timescale 1ns/10ps
module frs_assertions
   import frs_pkg::*;
#(
   parameter int POWERUP_CYCLES = 20
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic restart_n,
   input wire logic si,
   input wire logic so,
   input wire logic so_oe_n,
   input wire logic so_line
);
   logic [15:0] pu_cnt, next_pu_cnt;
   logic [15:0] hi_cnt, next_hi_cnt;
   logic [15:0] lo_cnt, next_lo_cnt;
   logic [3:0]  edge_cnt, next_edge_cnt;
   logic        sclk_d;

   // Cycles since reset, restart level spans, clock rises per select
   always_comb begin
      next_pu_cnt = (pu_cnt == 16'hffff) ? pu_cnt : pu_cnt + 16'h1;
      next_hi_cnt = restart_n ? hi_cnt + 16'h1 : 16'h0;
      next_lo_cnt = restart_n ? 16'h0 : lo_cnt + 16'h1;
      next_edge_cnt = cs_n ? 4'h0 : edge_cnt + {3'h0, sclk & ~sclk_d};
   end

   // Counter registers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pu_cnt <= 16'h0;
         hi_cnt <= 16'h0;
         lo_cnt <= 16'h0;
         edge_cnt <= 4'h0;
         sclk_d <= 1'b0;
      end else begin
         pu_cnt <= next_pu_cnt;
         hi_cnt <= next_hi_cnt;
         lo_cnt <= next_lo_cnt;
         edge_cnt <= next_edge_cnt;
         sclk_d <= sclk;
      end
   end

   default clocking dcb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // Link rules
   quiet_powerup_a : assert property (pu_cnt < POWERUP_CYCLES |-> cs_n && !sclk)
      else $error("select during powerup");
   restart_setup_a : assert property ($fell(restart_n) |-> hi_cnt >= SETUP_CYC)
      else $error("restart high too short");
   restart_width_a : assert property ($rose(restart_n) |-> lo_cnt >= RECOVERY_CYC)
      else $error("restart low shorter than recovery");
   deselect_restart_a : assert property (!restart_n |-> cs_n)
      else $error("select while restart low");
   select_hold_a : assert property ($rose(restart_n) |-> cs_n ##1 cs_n)
      else $error("select too soon after restart");
   output_float_a : assert property (!restart_n [*4] |-> so_oe_n)
      else $error("output driven during restart");
   idle_float_a : assert property (cs_n [*8] |-> so_oe_n)
      else $error("output driven while deselected");
   sclk_high_a : assert property ($rose(sclk) |-> sclk [*8])
      else $error("clock high phase too short");
   sclk_low_a : assert property ($fell(sclk) |-> !sclk [*8])
      else $error("clock low phase too short");
   byte_frame_a : assert property ($rose(cs_n) |-> edge_cnt == 4'h8)
      else $error("select frame not eight clocks");
   deselect_gap_a : assert property ($rose(cs_n) |-> cs_n [*2])
      else $error("deselect gap too short");

   cover property ($rose(restart_n));
   cover property ($rose(cs_n));
   cover property ($fell(so_oe_n));
   cover property (!so_oe_n && !so);
   cover property (!cs_n && si);
endmodule

// File: sim/flash_reset_sequencing_bench.sv
`timescale 1ns/10ps
module flash_reset_sequencing_bench;
   import frs_pkg::*;
   localparam int PU = 1000;
   localparam int RSP_LAT = 128;
   logic       sys_clk = 1'b0;
   logic       rst_n, clk_en, vcc_ok, por_fail, op_busy, req, warm_req;
   logic [7:0] tx_byte, rx_byte, req_byte, rsp_byte, dev_rx;
   logic       rx_valid, op_abort, standby, in_reset, ready, power_good, rsp_valid;
   logic       abort_seen;
   frs_class_e req_class;
   int         error_cnt = 0;
   int         n_tests = 0;
   int         n;

   always #25 sys_clk = ~sys_clk;

   frs_link_if link ();
   frs_device #(.POWERUP_CYCLES(PU)) u_frs_device (.sys_clk(sys_clk), .rst_n(rst_n),
      .clk_en(clk_en), .link(link.dev), .vcc_ok(vcc_ok), .por_fail(por_fail),
      .op_busy(op_busy), .tx_byte(tx_byte), .rx_byte(rx_byte), .rx_valid(rx_valid),
      .op_abort(op_abort), .standby(standby), .in_reset(in_reset));
   frs_host #(.POWERUP_CYCLES(PU)) u_frs_host (.sys_clk(sys_clk), .rst_n(rst_n),
      .clk_en(clk_en), .link(link.host), .req(req), .req_class(req_class),
      .req_byte(req_byte), .warm_req(warm_req), .ready(ready), .power_good(power_good),
      .rsp_byte(rsp_byte), .rsp_valid(rsp_valid));
   frs_assertions #(.POWERUP_CYCLES(PU)) u_frs_assertions (.sys_clk(sys_clk),
      .rst_n(rst_n), .sclk(link.sclk), .cs_n(link.cs_n), .restart_n(link.restart_n),
      .si(link.si), .so(link.so), .so_oe_n(link.so_oe_n), .so_line(link.so_line));

   // Catch device pulses
   always @(posedge sys_clk) begin
      if (rx_valid === 1'b1) dev_rx <= rx_byte;
      if (op_abort === 1'b1) abort_seen <= 1'b1;
   end

   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
      #2;
   endtask

   task automatic chk_val(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wait_ready(output int k);
      k = 0;
      while (ready !== 1'b1 && k < 2000) begin
         tick(1);
         k++;
      end
      chk_val("ready", 16'h1, {15'h0, ready});
   endtask

   // One byte each way
   task automatic send(input frs_class_e c, input logic [7:0] hb, input logic [7:0] db);
      int k;
      wait_ready(k);
      tx_byte = db;
      req_class = c;
      req_byte = hb;
      req = 1'b1;
      tick(1);
      req = 1'b0;
      k = 0;
      while (rsp_valid !== 1'b1 && k < 400) begin
         tick(1);
         k++;
      end
      chk_val("latency", 16'(RSP_LAT), 16'(k));
      chk_val("host byte", {8'h0, db}, {8'h0, rsp_byte});
      tick(8);
      chk_val("device byte", {8'h0, hb}, {8'h0, dev_rx});
   endtask

   task automatic warm(output int k);
      wait_ready(k);
      abort_seen = 1'b0;
      warm_req = 1'b1;
      tick(1);
      warm_req = 1'b0;
      wait_ready(k);
   endtask

   task automatic conclude;
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      {rst_n, req, warm_req, por_fail, op_busy, abort_seen} = '0;
      {clk_en, vcc_ok} = 2'b11;
      {tx_byte, req_byte, dev_rx} = '0;
      req_class = CLS_PLAIN_READ;
      tick(5);
      chk_val("reset flags", 16'h4, {13'h0, in_reset, standby, ready});
      rst_n = 1'b1;
      tick(900);
      chk_val("early cold", 16'h2, {14'h0, in_reset, power_good});
      wait_ready(n);
      chk_val("cold done", 16'h3, {13'h0, in_reset, power_good, standby});
      for (int i = 0; i < 4; i++)
         send(frs_class_e'(i), 8'ha5 ^ 8'(i), 8'h3c + 8'(i));
      op_busy = 1'b1;
      send(CLS_QPP, 8'h81, 8'h7e);
      tick(4);
      chk_val("busy standby", 16'h0, {15'h0, standby});
      warm(n);
      chk_val("warm time", 16'h1, {15'h0, n >= 700 && n <= 720});
      chk_val("abort", 16'h2, {14'h0, abort_seen, in_reset});
      tick(8);
      chk_val("warm standby", 16'h1, {15'h0, standby});
      send(CLS_SINGLE, 8'h5a, 8'hc3);
      op_busy = 1'b1;
      tick(200);
      op_busy = 1'b0;
      tick(8);
      chk_val("idle standby", 16'h1, {15'h0, standby});
      vcc_ok = 1'b0;
      por_fail = 1'b1;
      tick(3);
      chk_val("supply low", 16'h1, {15'h0, in_reset});
      vcc_ok = 1'b1;
      tick(PU - 100);
      chk_val("cold again", 16'h1, {15'h0, in_reset});
      tick(200);
      por_fail = 1'b0;
      chk_val("cold ended", 16'h0, {15'h0, in_reset});
      warm(n);
      chk_val("full rerun", 16'h1, {15'h0, in_reset});
      n = 0;
      while (in_reset !== 1'b0 && n < 1500) begin
         tick(1);
         n++;
      end
      chk_val("rerun length", 16'h1, {15'h0, n >= 200 && n <= 400});
      send(CLS_MULTI_READ, 8'h0f, 8'hf0);
      // Low clock enable freezes host, restart request not taken
      clk_en = 1'b0;
      warm_req = 1'b1;
      tick(20);
      chk_val("frozen", 16'h3, {14'h0, ready, link.restart_n});
      warm_req = 1'b0;
      clk_en = 1'b1;
      tick(2);
      chk_val("thawed", 16'h3, {14'h0, ready, link.restart_n});
      conclude;
   end

   // Watchdog
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      $display("unexpected run length expected end seen timeout");
      conclude;
   end
endmodule
